// >>> src/fbas_dev.sv
// Device end: block window, flash store, checksum commit and security levels
//
// The plain strobed port was chosen for this implementation.
module fbas_dev (
	// Clock and control
	input  wire logic mclk,
	input  wire logic rst_b,
	input  wire logic ce,
	// Command bus
	fbas_if.dev       bus,
	// Status seen by the user side
	output logic      sealed_flag,
	output logic      full_rights_flag,
	output logic      commit_done,
	output logic      commit_refused
);
	fbas_pkg::fbas_sec_t sec_r;
	logic [7:0]  cls_r;
	logic [7:0]  page_r;
	logic [7:0]  acc_r;
	logic [7:0]  sum_r;
	logic [7:0]  rdata_r;
	logic [7:0]  win_r [fbas_pkg::WIN_BYTES];
	logic [5:0]  wcnt_r;
	logic [3:0]  tgt_r;
	logic        tgt_ok_r;
	logic        tgt_a_r;
	logic        tgt_gen_r;
	logic [31:0] ukey_r;
	logic [31:0] fkey_r;
	logic [15:0] prev_r;
	logic        prev_v_r;
	logic        done_r;
	logic        refused_r;

	// Command decode
	wire is_wr    = bus.wr && ce;
	wire is_rd    = bus.rd && ce;
	wire sealed   = (sec_r == fbas_pkg::SEC_SEALED);
	wire win_hit  = (bus.addr >= fbas_pkg::CMD_WIN) && (bus.addr <= fbas_pkg::CMD_WIN_LAST);
	wire wr_cntl  = is_wr && (bus.addr == fbas_pkg::CMD_CNTL);
	wire wr_cls   = is_wr && (bus.addr == fbas_pkg::CMD_CLASS) && !sealed;
	wire wr_page  = is_wr && (bus.addr == fbas_pkg::CMD_PAGE);
	wire wr_acc   = is_wr && (bus.addr == fbas_pkg::CMD_ACC) && !sealed;
	wire wr_sum   = is_wr && (bus.addr == fbas_pkg::CMD_SUM);
	wire wr_win   = is_wr && win_hit;
	wire wr_key   = is_wr && (sec_r == fbas_pkg::SEC_FULL) && (bus.addr[7:2] == 6'h1C);
	wire [4:0] widx = bus.addr[4:0];

	// Selector values as they stand after this cycle's write
	wire [7:0] cls_nxt  = wr_cls  ? bus.wdata[7:0] : cls_r;
	wire [7:0] page_nxt = wr_page ? bus.wdata[7:0] : page_r;
	wire [7:0] acc_nxt  = wr_acc  ? bus.wdata[7:0] : acc_r;

	// General flash is reachable only unsealed with select at zero
	wire gen_mode = !sealed && (acc_nxt == fbas_pkg::ACC_GENERAL);
	wire mfg_cls  = (cls_nxt == fbas_pkg::MFG_CLASS) && (page_nxt < 8'h03);
	wire mfg_pick = (page_nxt >= fbas_pkg::MFG_A) && (page_nxt <= fbas_pkg::MFG_C);
	wire [3:0] gen_pg = mfg_cls ? fbas_pkg::MFG_BASE + page_nxt[3:0]
	                            : {1'b0, cls_nxt[1:0], page_nxt[0]};
	wire [3:0] mfg_pg = fbas_pkg::MFG_BASE + page_nxt[3:0] - 4'h1;
	wire [3:0] pg_nxt = gen_mode ? gen_pg : mfg_pg;
	wire ok_nxt       = gen_mode || mfg_pick;
	wire a_nxt        = !gen_mode && (page_nxt == fbas_pkg::MFG_A);

	// A new selection maps the chosen flash block into the window
	wire load = wr_cls || wr_page || (wr_acc && bus.wdata[7:0] == fbas_pkg::ACC_GENERAL);

	// Commit check: checksum, length, target and rights all hold
	logic [255:0] win_flat;
	logic [7:0]   sum_exp;
	wire len_ok   = (wcnt_r <= fbas_pkg::WIN_MAX);
	// A block loaded as general flash must not be programmed once the level drops to sealed
	wire a_locked = (tgt_a_r || tgt_gen_r) && sealed;
	wire commit   = wr_sum && (bus.wdata[7:0] == sum_exp) && len_ok && tgt_ok_r && !a_locked;

	fbas_sum u_sum (
		.win_flat (win_flat),
		.sum_exp  (sum_exp)
	);

	// Per byte: flash column and window cell; flash has no reset so it survives reset
	genvar i;
	generate
		for (i = 0; i < fbas_pkg::WIN_BYTES; i++) begin : g_byte
			logic [7:0] col [fbas_pkg::PAGES];
			assign win_flat[i*8 +: 8] = win_r[i];
			always_ff @(posedge mclk) begin
				if (ce && commit) begin
					col[tgt_r] <= win_r[i];
				end
			end
			always_ff @(posedge mclk) begin
				if (!rst_b) begin
					win_r[i] <= 8'h00;
				end else if (ce && load && ok_nxt) begin
					win_r[i] <= col[pg_nxt];
				end else if (wr_win && widx == 5'(i)) begin
					win_r[i] <= bus.wdata[7:0];
				end
			end
		end
	endgenerate

	// Selectors and the commit target
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cls_r    <= 8'h00;
			page_r   <= 8'h00;
			acc_r    <= fbas_pkg::ACC_GENERAL;
			tgt_r    <= 4'h0;
			tgt_ok_r <= 1'b0;
			tgt_a_r   <= 1'b0;
			tgt_gen_r <= 1'b0;
		end else if (ce) begin
			cls_r  <= cls_nxt;
			page_r <= page_nxt;
			acc_r  <= acc_nxt;
			if (load) begin
				tgt_r     <= pg_nxt;
				tgt_ok_r  <= ok_nxt;
				tgt_a_r   <= a_nxt;
				tgt_gen_r <= gen_mode;
			end
		end
	end

	// Window write count since the last load or commit; saturates past the limit
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			wcnt_r <= 6'h00;
		end else if (ce) begin
			if (load || commit) begin
				wcnt_r <= 6'h00;
			end else if (wr_win && wcnt_r != fbas_pkg::WIN_OVER) begin
				wcnt_r <= wcnt_r + 6'h01;
			end
		end
	end

	// Last checksum byte written and commit result pulses
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			sum_r     <= 8'h00;
			done_r    <= 1'b0;
			refused_r <= 1'b0;
		end else if (ce) begin
			if (wr_sum) begin
				sum_r <= bus.wdata[7:0];
			end
			done_r    <= commit;
			refused_r <= wr_sum && !commit;
		end
	end

	// Keys, word 0 in the upper half; writable only at full access
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ukey_r <= fbas_pkg::UKEY_RST;
			fkey_r <= fbas_pkg::FKEY_RST;
		end else if (wr_key) begin
			unique case (bus.addr)
				fbas_pkg::CMD_UKEY0: ukey_r[31:16] <= bus.wdata;
				fbas_pkg::CMD_UKEY1: ukey_r[15:0]  <= bus.wdata;
				fbas_pkg::CMD_FKEY0: fkey_r[31:16] <= bus.wdata;
				default:             fkey_r[15:0]  <= bus.wdata;
			endcase
		end
	end

	// Key pair: previous word is key 1, this word key 0, both byte-swapped on the wire
	wire [31:0] key_rx = {bus.wdata[7:0], bus.wdata[15:8], prev_r[7:0], prev_r[15:8]};
	wire hit_u = wr_cntl && prev_v_r && (key_rx == ukey_r) && sealed;
	wire hit_f = wr_cntl && prev_v_r && (key_rx == fkey_r) && (sec_r == fbas_pkg::SEC_UNSEALED);
	wire seal  = wr_cntl && (bus.wdata == fbas_pkg::SUB_SEAL);

	// Every control write pairs only with the one just before it
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			prev_r   <= 16'h0000;
			prev_v_r <= 1'b0;
		end else if (wr_cntl) begin
			prev_r   <= bus.wdata;
			prev_v_r <= !(hit_u || hit_f);
		end
	end

	// Security level; sealed after reset, the safe choice for an unknown host
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			sec_r <= fbas_pkg::SEC_SEALED;
		end else if (ce) begin
			if (seal) begin
				sec_r <= fbas_pkg::SEC_SEALED;
			end else if (hit_u) begin
				sec_r <= fbas_pkg::SEC_UNSEALED;
			end else if (hit_f) begin
				sec_r <= fbas_pkg::SEC_FULL;
			end
		end
	end

	// Read mux; unmapped codes read as zero
	logic [7:0] stat_b;
	always_comb begin
		stat_b                    = 8'h00;
		stat_b[fbas_pkg::SS_BIT]   = sealed;
		stat_b[fbas_pkg::FULL_BIT] = (sec_r != fbas_pkg::SEC_FULL);
	end
	wire [7:0] rd_val =
		win_hit                          ? win_r[widx] :
		(bus.addr == fbas_pkg::CMD_STAT)  ? stat_b :
		(bus.addr == fbas_pkg::CMD_CLASS) ? cls_r :
		(bus.addr == fbas_pkg::CMD_PAGE)  ? page_r :
		(bus.addr == fbas_pkg::CMD_SUM)   ? sum_r :
		(bus.addr == fbas_pkg::CMD_ACC)   ? acc_r : 8'h00;

	// Read data stand for one cycle only
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rdata_r <= 8'h00;
		end else if (ce) begin
			rdata_r <= is_rd ? rd_val : 8'h00;
		end
	end

	assign bus.rdata        = rdata_r;
	assign sealed_flag      = stat_b[fbas_pkg::SS_BIT];
	assign full_rights_flag = stat_b[fbas_pkg::FULL_BIT];
	assign commit_done      = done_r;
	assign commit_refused   = refused_r;
endmodule

// >>> src/fbas_pkg.sv
// Package of command codes, field positions, reset values and types for the flash block access
package fbas_pkg;
	// Command codes
	localparam logic [7:0] CMD_CNTL      = 8'h00;
	localparam logic [7:0] CMD_STAT      = 8'h01;
	localparam logic [7:0] CMD_CLASS     = 8'h3E;
	localparam logic [7:0] CMD_PAGE      = 8'h3F;
	localparam logic [7:0] CMD_WIN       = 8'h40;
	localparam logic [7:0] CMD_WIN_LAST  = 8'h5F;
	localparam logic [7:0] CMD_SUM       = 8'h60;
	localparam logic [7:0] CMD_ACC       = 8'h61;
	localparam logic [7:0] CMD_UKEY0     = 8'h70;
	localparam logic [7:0] CMD_UKEY1     = 8'h71;
	localparam logic [7:0] CMD_FKEY0     = 8'h72;
	localparam logic [7:0] CMD_FKEY1     = 8'h73;
	// Window and flash geometry
	localparam int         WIN_BYTES     = 32;
	localparam logic [5:0] WIN_MAX       = 6'h20;
	localparam logic [5:0] WIN_OVER      = 6'h21;
	localparam int         PAGES         = 11;
	localparam logic [3:0] MFG_BASE      = 4'h8;
	localparam logic [7:0] MFG_CLASS     = 8'h3A;
	localparam logic [7:0] MFG_A         = 8'h01;
	localparam logic [7:0] MFG_C         = 8'h03;
	localparam logic [7:0] ACC_GENERAL   = 8'h00;
	localparam logic [7:0] SUM_BASE      = 8'hFF;
	// Status byte fields and control subcommands
	localparam int         SS_BIT        = 5;
	localparam int         FULL_BIT      = 6;
	localparam logic [15:0] SUB_SEAL     = 16'h0020;
	localparam logic [15:0] SUB_STATUS   = 16'h0000;
	// Key reset values, arbitrary
	localparam logic [31:0] UKEY_RST     = 32'h3672_0414;
	localparam logic [31:0] FKEY_RST     = 32'hFFFF_FFFF;
	// Types
	typedef enum logic [1:0] {SEC_FULL, SEC_UNSEALED, SEC_SEALED} fbas_sec_t;
	typedef enum logic [1:0] {OP_WR, OP_RD, OP_COMMIT, OP_KEY} fbas_op_t;
endpackage

// >>> src/fbas_if.sv
// Command bus between host processor and flash access device
interface fbas_if;
	logic [7:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;
	modport dev  (input addr, input wdata, input wr, input rd, output rdata);
	modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// >>> src/fbas_sum.sv
// Expected checksum of a 32-byte window
module fbas_sum (
	// Window contents, byte 0 in the low bits
	input  wire logic [255:0] win_flat,
	// Expected checksum
	output logic      [7:0]   sum_exp
);
	logic [7:0] part [fbas_pkg::WIN_BYTES+1];

	// Running low-byte sum; carries beyond eight bits are dropped on purpose
	assign part[0] = 8'h00;
	genvar i;
	generate
		for (i = 0; i < fbas_pkg::WIN_BYTES; i++) begin : g_add
			assign part[i+1] = part[i] + win_flat[i*8 +: 8];
		end
	endgenerate

	// Complement as 255 minus the low byte
	assign sum_exp = fbas_pkg::SUM_BASE - part[fbas_pkg::WIN_BYTES];
endmodule

// >>> src/fbas_host.sv
// Host end: raw command access, checksum commit and key sequences
module fbas_host (
	// Clock and control
	input  wire logic               mclk,
	input  wire logic               rst_b,
	input  wire logic               ce,
	// Command bus
	fbas_if.host                    bus,
	// User requests
	input  wire logic               req_valid,
	input  wire fbas_pkg::fbas_op_t req_op,
	input  wire logic [7:0]         req_addr,
	input  wire logic [31:0]        req_data,
	output logic                    req_ready,
	// User answers
	output logic                    rd_valid,
	output logic [7:0]              rd_data,
	output logic                    key_refused
);
	typedef enum logic [1:0] {H_IDLE, H_SUM, H_KEY} fbas_hst_t;
	fbas_hst_t   st_r;
	logic [7:0]  addr_r;
	logic [15:0] wdata_r;
	logic        wr_r;
	logic        rd_r;
	logic        pend0_r;
	logic        pend1_r;
	logic        user_rd_r;
	logic        user_rd2_r;
	logic        rdv_r;
	logic [7:0]  rdd_r;
	logic [5:0]  iss_r;
	logic [5:0]  got_r;
	logic [7:0]  acc_r;
	logic [15:0] key0_r;
	logic        kref_r;

	// Request acceptance and subcommand clash test on the key words
	wire take    = ce && req_valid && (st_r == H_IDLE);
	wire clash   = (req_data[15:0] == fbas_pkg::SUB_SEAL) || (req_data[31:16] == fbas_pkg::SUB_SEAL)
	            || (req_data[15:0] == fbas_pkg::SUB_STATUS)
	            || (req_data[31:16] == fbas_pkg::SUB_STATUS);
	wire [7:0] acc_nxt = acc_r + bus.rdata;
	wire got_all = pend1_r && (got_r == fbas_pkg::WIN_MAX - 6'h01);

	// Sequencer; strobes last one cycle
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			st_r    <= H_IDLE;
			addr_r  <= 8'h00;
			wdata_r <= 16'h0000;
			wr_r    <= 1'b0;
			rd_r    <= 1'b0;
			iss_r   <= 6'h00;
			got_r   <= 6'h00;
			acc_r   <= 8'h00;
			key0_r  <= 16'h0000;
			kref_r  <= 1'b0;
		end else if (ce) begin
			wr_r   <= 1'b0;
			rd_r   <= 1'b0;
			kref_r <= 1'b0;
			unique case (st_r)
				H_IDLE: begin
					if (take) begin
						unique case (req_op)
							fbas_pkg::OP_WR: begin
								addr_r  <= req_addr;
								wdata_r <= req_data[15:0];
								wr_r    <= 1'b1;
							end
							fbas_pkg::OP_RD: begin
								addr_r <= req_addr;
								rd_r   <= 1'b1;
							end
							fbas_pkg::OP_COMMIT: begin
								iss_r <= 6'h00;
								got_r <= 6'h00;
								acc_r <= 8'h00;
								st_r  <= H_SUM;
							end
							fbas_pkg::OP_KEY: begin
								if (clash) begin
									kref_r <= 1'b1;
								end else begin
									// Key 1 goes first, bytes swapped
									addr_r  <= fbas_pkg::CMD_CNTL;
									wdata_r <= {req_data[7:0], req_data[15:8]};
									key0_r  <= {req_data[23:16], req_data[31:24]};
									wr_r    <= 1'b1;
									st_r    <= H_KEY;
								end
							end
						endcase
					end
				end
				H_KEY: begin
					// Key 0 right behind, nothing else on the control code between
					wdata_r <= key0_r;
					wr_r    <= 1'b1;
					st_r    <= H_IDLE;
				end
				H_SUM: begin
					// Read the whole window back, one read a cycle
					if (iss_r != fbas_pkg::WIN_MAX) begin
						addr_r <= fbas_pkg::CMD_WIN + {2'h0, iss_r};
						rd_r   <= 1'b1;
						iss_r  <= iss_r + 6'h01;
					end
					if (pend1_r) begin
						acc_r <= acc_nxt;
						got_r <= got_r + 6'h01;
					end
					if (got_all) begin
						addr_r  <= fbas_pkg::CMD_SUM;
						wdata_r <= {8'h00, fbas_pkg::SUM_BASE - acc_nxt};
						wr_r    <= 1'b1;
						st_r    <= H_IDLE;
					end
				end
				default: st_r <= H_IDLE;
			endcase
		end
	end

	// Read return tracking: data stand in the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			pend0_r    <= 1'b0;
			pend1_r    <= 1'b0;
			user_rd_r  <= 1'b0;
			user_rd2_r <= 1'b0;
			rdv_r      <= 1'b0;
			rdd_r      <= 8'h00;
		end else if (ce) begin
			// Commit reads and user reads travel apart, so neither is counted as the other
			pend0_r    <= (st_r == H_SUM) && (iss_r != fbas_pkg::WIN_MAX);
			pend1_r    <= pend0_r;
			user_rd_r  <= take && (req_op == fbas_pkg::OP_RD);
			user_rd2_r <= user_rd_r;
			rdv_r      <= user_rd2_r;
			if (user_rd2_r) begin
				rdd_r <= bus.rdata;
			end
		end
	end

	assign bus.addr    = addr_r;
	assign bus.wdata   = wdata_r;
	assign bus.wr      = wr_r;
	assign bus.rd      = rd_r;
	assign req_ready   = (st_r == H_IDLE);
	assign rd_valid    = rdv_r;
	assign rd_data     = rdd_r;
	assign key_refused = kref_r;
endmodule

// >>> sim/fbas_monitor.sv
// Checker of the command bus between the host end and the device end
module fbas_monitor (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst_b,
	// Command bus
	input wire logic [7:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [7:0]  rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// Bus decodes; any selector write may reload the window, so it ends tracking
	wire win = addr[7:5] == 3'h2;
	wire cw = wr && addr == fbas_pkg::CMD_CNTL;
	wire sub = wdata == fbas_pkg::SUB_SEAL || wdata == fbas_pkg::SUB_STATUS;
	wire ld = wr && (addr == fbas_pkg::CMD_CLASS || addr == fbas_pkg::CMD_PAGE
		|| addr == fbas_pkg::CMD_ACC);
	logic       rd_q, cw_q, wv_r, clean_r;
	logic [5:0] cnt_r;
	logic [7:0] acc_r, wa_r, wd_r;
	// Running sum of window bytes read since the last write
	wire [5:0] cnt_now = cnt_r + {5'h00, rd_q};
	wire [7:0] sum_now = acc_r + (rd_q ? rdata : 8'h00);
	always_ff @(posedge mclk) begin
		rd_q <= rst_b && rd && win;
		cw_q <= rst_b && cw;
		cnt_r <= (!rst_b || wr) ? 6'h00 : cnt_now;
		acc_r <= (!rst_b || wr) ? 8'h00 : sum_now;
	end
	// Last window byte written, and whether the window is still as reset left it
	always_ff @(posedge mclk) begin
		if (wr && win) begin
			wa_r <= addr;
			wd_r <= wdata[7:0];
		end
		wv_r <= rst_b && ((wr && win) || (wv_r && !ld));
		clean_r <= !rst_b || (clean_r && !ld && !(wr && win));
	end
	a_one_strobe: assert property (!(wr && rd))
		else $error("read and write strobes together");
	a_rdata_quiet: assert property (rdata != 8'h00 |-> $past(rd))
		else $error("read data outside its answer cycle");
	a_key_pair: assert property (cw && !sub |-> (cw_q or ##1 cw))
		else $error("key word without its partner");
	a_key_legal: assert property (cw && cw_q |-> !sub && !$past(sub))
		else $error("key word equals a subcommand");
	a_key_gap: assert property (cw && cw_q |=> !cw)
		else $error("third control write after a key pair");
	a_commit_sum: assert property (wr && addr == fbas_pkg::CMD_SUM && cnt_now == 6'h20
		|-> wdata[7:0] == 8'hFF - sum_now)
		else $error("checksum does not match the bytes read");
	a_read_back: assert property (rd && win && wv_r && addr == wa_r |=> rdata == $past(wd_r))
		else $error("window byte read back differs");
	a_reset_window: assert property (rd && win && clean_r |=> rdata == 8'h00)
		else $error("window not clear after reset");
endmodule

// >>> sim/fbas_tb_top.sv
// Testbench joining the host end to the device end over the command bus
module fbas_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		fbas_pkg::fbas_op_t op;
		logic [7:0]         a;
		logic [31:0]        d;
		logic [2:0]         k;
		logic [7:0]         e;
	} fbas_row_t;
	logic mclk, rst_b, ce, req_valid, req_ready, rd_valid, key_refused;
	logic sealed_flag, full_rights_flag, commit_done, commit_refused;
	logic s_rd, s_done, s_ref, s_kref;
	fbas_pkg::fbas_op_t req_op;
	logic [7:0]  req_addr, rd_data, sb;
	logic [31:0] req_data;
	int          n_fail, num_checks;
	fbas_if bus_if ();
	fbas_dev fbas_dev_i (.mclk(mclk), .rst_b(rst_b), .ce(ce), .bus(bus_if),
		.sealed_flag(sealed_flag), .full_rights_flag(full_rights_flag),
		.commit_done(commit_done), .commit_refused(commit_refused));
	fbas_host fbas_host_i (.mclk(mclk), .rst_b(rst_b), .ce(ce), .bus(bus_if),
		.req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
		.req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .key_refused(key_refused));
	fbas_monitor fbas_monitor_i (.mclk(mclk), .rst_b(rst_b), .addr(bus_if.addr),
		.wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata));
	// Kinds: 1 read byte, 2 commit done, 3 commit refused, 4 sealed, 5 full rights, 6 key refused
	localparam fbas_row_t ROWS [26] = '{
		'{fbas_pkg::OP_WR, 8'h3F, 32'h2, 3'd0, 8'h00},
		'{fbas_pkg::OP_WR, 8'hFF, 32'd32, 3'd0, 8'h00},
		'{fbas_pkg::OP_COMMIT, 8'h00, 32'h0, 3'd2, 8'h01},
		'{fbas_pkg::OP_WR, 8'h45, 32'h99, 3'd0, 8'h00},
		'{fbas_pkg::OP_RD, 8'h45, 32'h0, 3'd1, 8'h99},
		'{fbas_pkg::OP_WR, 8'h3F, 32'h2, 3'd0, 8'h00},
		'{fbas_pkg::OP_RD, 8'h45, 32'h0, 3'd1, 8'h26},
		'{fbas_pkg::OP_KEY, 8'h00, 32'h0020_1234, 3'd6, 8'h01},
		'{fbas_pkg::OP_KEY, 8'h00, 32'h1111_2222, 3'd4, 8'h01},
		'{fbas_pkg::OP_KEY, 8'h00, fbas_pkg::UKEY_RST, 3'd4, 8'h00},
		'{fbas_pkg::OP_KEY, 8'h00, fbas_pkg::FKEY_RST, 3'd5, 8'h00},
		'{fbas_pkg::OP_WR, 8'h70, 32'h5678, 3'd0, 8'h00},
		'{fbas_pkg::OP_WR, 8'h71, 32'h1234, 3'd0, 8'h00},
		'{fbas_pkg::OP_WR, 8'h61, 32'h0, 3'd0, 8'h00},
		'{fbas_pkg::OP_WR, 8'h3E, 32'h0, 3'd0, 8'h00},
		'{fbas_pkg::OP_WR, 8'h3F, 32'h1, 3'd0, 8'h00},
		'{fbas_pkg::OP_WR, 8'hFF, 32'd32, 3'd0, 8'h00},
		'{fbas_pkg::OP_COMMIT, 8'h00, 32'h0, 3'd2, 8'h01},
		'{fbas_pkg::OP_WR, 8'h3F, 32'h0, 3'd0, 8'h00},
		'{fbas_pkg::OP_WR, 8'h3F, 32'h1, 3'd0, 8'h00},
		'{fbas_pkg::OP_RD, 8'h50, 32'h0, 3'd1, 8'h73},
		'{fbas_pkg::OP_WR, 8'h3E, 32'h3A, 3'd0, 8'h00},
		'{fbas_pkg::OP_RD, 8'h45, 32'h0, 3'd1, 8'h26},
		'{fbas_pkg::OP_WR, 8'h00, 32'h0020, 3'd4, 8'h01},
		'{fbas_pkg::OP_WR, 8'h70, 32'h0BAD, 3'd0, 8'h00},
		'{fbas_pkg::OP_KEY, 8'h00, 32'h5678_1234, 3'd4, 8'h00}
	};
	// Free-running 40 MHz clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	function automatic logic [7:0] pat(input int i);
		return 8'(i * 7 + 3);
	endfunction
	function automatic logic [8:0] got(input logic [2:0] k);
		case (k)
			3'd1: return {s_rd, rd_data};
			3'd2: return {8'h00, s_done};
			3'd3: return {8'h00, s_ref};
			3'd4: return {8'h00, sealed_flag};
			3'd5: return {8'h00, full_rights_flag};
			default: return {8'h00, s_kref};
		endcase
	endfunction
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One request; the watch span covers a full commit so its pulse is not missed
	task automatic run(input fbas_pkg::fbas_op_t op, input logic [7:0] a, input logic [31:0] d);
		int i;
		req_valid <= 1'b1;
		req_op <= op;
		req_addr <= a;
		req_data <= d;
		i = 0;
		@(negedge mclk);
		while (req_ready !== 1'b1 && i < 100) begin
			i++;
			@(negedge mclk);
		end
		// A host that never becomes ready is a failure, not a skipped request
		if (i == 100) begin
			n_fail++;
			$display("MISMATCH t=%0t request never accepted", $time);
		end
		@(posedge mclk);
		req_valid <= 1'b0;
		{s_rd, s_done, s_ref, s_kref} = 4'h0;
		repeat (45) begin
			@(negedge mclk);
			s_rd |= rd_valid === 1'b1;
			s_done |= commit_done === 1'b1;
			s_ref |= commit_refused === 1'b1;
			s_kref |= key_refused === 1'b1;
		end
		@(posedge mclk);
	endtask
	task automatic fill(input int n);
		for (int i = 0; i < n; i++) begin
			run(fbas_pkg::OP_WR, 8'h40 + 8'(i % 32), {24'h0, pat(i)});
		end
	endtask
	// Address 0xFF stands for a run of window writes
	task automatic step(input fbas_pkg::fbas_op_t op, input logic [7:0] a, input logic [31:0] d,
		input logic [2:0] k, input logic [7:0] e);
		if (a == 8'hFF) fill(d);
		else run(op, a, d);
		if (k != 3'd0) chk(got(k), {k == 3'd1, e});
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Watchdog well beyond the expected run of about 7600 cycles
	initial begin
		repeat (30000) @(posedge mclk);
		n_fail++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		give_verdict;
	end
	initial begin
		{rst_b, req_valid, req_addr, req_data} = '0;
		req_op = fbas_pkg::OP_WR;
		ce = 1'b1;
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		foreach (ROWS[n]) step(ROWS[n].op, ROWS[n].a, ROWS[n].d, ROWS[n].k, ROWS[n].e);
		// Second reset: keys and levels return, flash contents must survive
		rst_b <= 1'b0;
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		chk({7'h00, sealed_flag, full_rights_flag}, 9'h003);
		step(fbas_pkg::OP_RD, 8'h40, 32'h0, 3'd1, 8'h00);
		step(fbas_pkg::OP_WR, 8'h3F, 32'h2, 3'd0, 8'h00);
		step(fbas_pkg::OP_RD, 8'h45, 32'h0, 3'd1, 8'h26);
		fill(33);
		step(fbas_pkg::OP_COMMIT, 8'h00, 32'h0, 3'd3, 8'h01);
		sb = 8'h00;
		for (int i = 0; i < 32; i++) sb += pat(i);
		sb = 8'hFF - sb;
		step(fbas_pkg::OP_WR, 8'h3F, 32'h2, 3'd0, 8'h00);
		step(fbas_pkg::OP_WR, 8'h60, {24'h0, sb ^ 8'h5A}, 3'd3, 8'h01);
		step(fbas_pkg::OP_WR, 8'h60, {24'h0, sb}, 3'd2, 8'h01);
		step(fbas_pkg::OP_WR, 8'h3F, 32'h1, 3'd0, 8'h00);
		fill(32);
		step(fbas_pkg::OP_COMMIT, 8'h00, 32'h0, 3'd3, 8'h01);
		// Clock enable low: a write offered now must never reach the window
		ce <= 1'b0;
		run(fbas_pkg::OP_WR, 8'h45, 32'h55);
		ce <= 1'b1;
		step(fbas_pkg::OP_RD, 8'h45, 32'h0, 3'd1, 8'h26);
		give_verdict;
	end
endmodule
